// [verilog/lsb_pkg.sv]
// What this block does
// RQ1 - AND a register with register or immediate, result to destination, B/W/L
// RQ2 - OR a register with register or immediate, result to destination, B/W/L
// RQ3 - XOR a register with register or immediate, result to destination, B/W/L
// RQ4 - Invert every bit of the destination register, B/W/L
// RQ5 - Arithmetic shift left/right in place; right shift keeps the sign bit
// RQ6 - Logical shift left/right in place, zero fills the vacated bit
// RQ7 - Rotate left/right in place, leaving bit re-enters other end
// RQ8 - Rotate through carry: outgoing bit to carry, old carry enters
// RQ9 - Bit set forces one byte bit to 1; index immediate or register
// RQ10 - Bit clear forces selected bit to 0; index immediate or register
// RQ11 - Bit toggle inverts selected bit and writes the byte back
// RQ12 - Bit probe loads zero flag with inverse of bit, operand unchanged
// RQ13 - Carry becomes carry AND selected bit
// RQ14 - Carry becomes carry AND inverted bit; immediate index only
// RQ15 - Carry becomes carry OR selected bit
// RQ16 - Carry becomes carry OR inverted bit; immediate index only
// RQ17 - Carry becomes carry XOR selected bit
// RQ18 - Carry becomes carry XOR inverted bit; immediate index only
// RQ19 - Carry takes the selected bit, operand unchanged
// RQ20 - Carry takes the inverted bit; immediate index only
// RQ21 - Selected bit takes carry, other seven bits kept
// RQ22 - Selected bit takes inverted carry; immediate index only
// RQ23 - Memory bit change reads byte, alters one bit, writes same address
package lsb_pkg;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 3;
  localparam int ADDR_W = 16;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF;
  localparam logic [4:0] MSB_BYTE = 5'h07;
  localparam logic [4:0] MSB_WORD = 5'h0F;
  localparam logic [4:0] MSB_LONG = 5'h1F;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } lsb_size_e;

  typedef enum logic [4:0] {
    OP_AND = 5'h00, OP_OR = 5'h01, OP_XOR = 5'h02, OP_NOT = 5'h03,
    OP_ARITH_SHIFT_LEFT = 5'h04, OP_ARITH_SHIFT_RIGHT = 5'h05,
    OP_LOGIC_SHIFT_LEFT = 5'h06, OP_LOGIC_SHIFT_RIGHT = 5'h07,
    OP_ROTATE_LEFT = 5'h08, OP_ROTATE_RIGHT = 5'h09,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h0A, OP_ROTATE_RIGHT_VIA_CARRY = 5'h0B,
    OP_BIT_FORCE_ONE = 5'h0C, OP_BIT_FORCE_ZERO = 5'h0D, OP_BIT_TOGGLE = 5'h0E,
    OP_BIT_PROBE = 5'h0F, OP_BIT_AND_TO_CARRY = 5'h10, OP_INV_BIT_AND_TO_CARRY = 5'h11,
    OP_BIT_OR_TO_CARRY = 5'h12, OP_INV_BIT_OR_TO_CARRY = 5'h13,
    OP_BIT_XOR_TO_CARRY = 5'h14, OP_INV_BIT_XOR_TO_CARRY = 5'h15,
    OP_BIT_LOAD_CARRY = 5'h16, OP_INV_BIT_LOAD_CARRY = 5'h17,
    OP_CARRY_STORE_BIT = 5'h18, OP_INV_CARRY_STORE_BIT = 5'h19
  } lsb_op_e;

  typedef struct packed {
    lsb_op_e op;
    lsb_size_e size;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] source_register;
    logic [DATA_W-1:0] imm;
    logic use_imm;
    logic [IDX_W-1:0] bit_imm;
    logic idx_from_reg;
    logic mem_operand;
    logic [ADDR_W-1:0] mem_addr;
    logic carry;
  } lsb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic reg_we;
    logic c;
    logic z;
    logic n;
    logic v;
    logic c_upd;
    logic z_upd;
    logic nv_upd;
    logic illegal;
  } lsb_rsp_s;

  function automatic logic [31:0] size_mask(input lsb_size_e s);
    if (s == SZ_BYTE) return MASK_BYTE;
    else if (s == SZ_WORD) return MASK_WORD;
    else return MASK_LONG;
  endfunction : size_mask

  function automatic logic [4:0] msb_pos(input lsb_size_e s);
    if (s == SZ_BYTE) return MSB_BYTE;
    else if (s == SZ_WORD) return MSB_WORD;
    else return MSB_LONG;
  endfunction : msb_pos

  function automatic logic is_bit_op(input lsb_op_e o);
    return o >= OP_BIT_FORCE_ONE;
  endfunction : is_bit_op
endpackage : lsb_pkg

// [verilog/lsb_word_unit.sv]
`timescale 1ns/1ps
module lsb_word_unit (
  // Operation
  input wire lsb_pkg::lsb_op_e op,
  input wire lsb_pkg::lsb_size_e size,
  input wire logic [31:0] dst,
  input wire logic [31:0] opnd,
  input wire logic carry_in,
  // Result
  output logic [31:0] result,
  output logic c_out,
  output logic c_upd,
  output logic n_out,
  output logic z_out,
  output logic v_out
);
  logic [31:0] mask;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] r;
  logic [4:0] msb;
  logic top;

  always_comb begin
    mask = lsb_pkg::size_mask(size);
    msb = lsb_pkg::msb_pos(size);
    a = dst & mask;
    b = opnd & mask;
    top = a[msb];
    r = a;
    c_out = carry_in;
    c_upd = 1'b0;
    v_out = 1'b0;
    case (op)
      lsb_pkg::OP_AND: r = a & b; // RQ1
      lsb_pkg::OP_OR: r = a | b; // RQ2
      lsb_pkg::OP_XOR: r = a ^ b; // RQ3
      lsb_pkg::OP_NOT: r = ~a; // RQ4
      lsb_pkg::OP_ARITH_SHIFT_LEFT, lsb_pkg::OP_LOGIC_SHIFT_LEFT: begin
        r = a << 1; // RQ5 RQ6
        c_out = top;
        c_upd = 1'b1;
        if (op == lsb_pkg::OP_ARITH_SHIFT_LEFT) v_out = top ^ a[msb - 5'h01];
      end
      lsb_pkg::OP_ARITH_SHIFT_RIGHT: begin
        r = a >> 1;
        r[msb] = top; // RQ5
        c_out = a[0];
        c_upd = 1'b1;
      end
      lsb_pkg::OP_LOGIC_SHIFT_RIGHT: begin
        r = a >> 1; // RQ6
        c_out = a[0];
        c_upd = 1'b1;
      end
      lsb_pkg::OP_ROTATE_LEFT, lsb_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        r = a << 1;
        r[0] = (op == lsb_pkg::OP_ROTATE_LEFT) ? top : carry_in; // RQ7 RQ8
        c_out = top;
        c_upd = 1'b1;
      end
      lsb_pkg::OP_ROTATE_RIGHT, lsb_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        r = a >> 1;
        r[msb] = (op == lsb_pkg::OP_ROTATE_RIGHT) ? a[0] : carry_in; // RQ7 RQ8
        c_out = a[0];
        c_upd = 1'b1;
      end
      default: r = a;
    endcase
    r = r & mask;
    n_out = r[msb];
    z_out = (r == 32'h0000_0000);
    result = (dst & ~mask) | r;
  end
endmodule : lsb_word_unit

// [verilog/lsb_bit_unit.sv]
`timescale 1ns/1ps
module lsb_bit_unit (
  // Operation
  input wire lsb_pkg::lsb_op_e op,
  input wire logic [7:0] byte_in,
  input wire logic [2:0] idx,
  input wire logic idx_from_reg,
  input wire logic carry_in,
  // Result
  output logic [7:0] byte_out,
  output logic writes,
  output logic c_out,
  output logic c_upd,
  output logic z_out,
  output logic z_upd,
  output logic illegal
);
  logic sel;

  always_comb begin
    sel = byte_in[idx];
    byte_out = byte_in;
    writes = 1'b0;
    c_out = carry_in;
    c_upd = 1'b0;
    z_out = 1'b0;
    z_upd = 1'b0;
    illegal = 1'b0;
    case (op)
      lsb_pkg::OP_BIT_FORCE_ONE: begin
        byte_out[idx] = 1'b1; // RQ9
        writes = 1'b1;
      end
      lsb_pkg::OP_BIT_FORCE_ZERO: begin
        byte_out[idx] = 1'b0; // RQ10
        writes = 1'b1;
      end
      lsb_pkg::OP_BIT_TOGGLE: begin
        byte_out[idx] = ~sel; // RQ11
        writes = 1'b1;
      end
      lsb_pkg::OP_BIT_PROBE: begin
        z_out = ~sel; // RQ12
        z_upd = 1'b1;
      end
      lsb_pkg::OP_BIT_AND_TO_CARRY: c_out = carry_in & sel; // RQ13
      lsb_pkg::OP_INV_BIT_AND_TO_CARRY: c_out = carry_in & ~sel; // RQ14
      lsb_pkg::OP_BIT_OR_TO_CARRY: c_out = carry_in | sel; // RQ15
      lsb_pkg::OP_INV_BIT_OR_TO_CARRY: c_out = carry_in | ~sel; // RQ16
      lsb_pkg::OP_BIT_XOR_TO_CARRY: c_out = carry_in ^ sel; // RQ17
      lsb_pkg::OP_INV_BIT_XOR_TO_CARRY: c_out = carry_in ^ ~sel; // RQ18
      lsb_pkg::OP_BIT_LOAD_CARRY: c_out = sel; // RQ19
      lsb_pkg::OP_INV_BIT_LOAD_CARRY: c_out = ~sel; // RQ20
      lsb_pkg::OP_CARRY_STORE_BIT: begin
        byte_out[idx] = carry_in; // RQ21
        writes = 1'b1;
      end
      lsb_pkg::OP_INV_CARRY_STORE_BIT: begin
        byte_out[idx] = ~carry_in; // RQ22
        writes = 1'b1;
      end
      default: byte_out = byte_in;
    endcase
    if (op >= lsb_pkg::OP_BIT_AND_TO_CARRY && op <= lsb_pkg::OP_INV_BIT_LOAD_CARRY) begin
      c_upd = 1'b1;
    end
    // Inverted forms take an immediate index only
    if (idx_from_reg && (op == lsb_pkg::OP_INV_BIT_AND_TO_CARRY
        || op == lsb_pkg::OP_INV_BIT_OR_TO_CARRY || op == lsb_pkg::OP_INV_BIT_XOR_TO_CARRY
        || op == lsb_pkg::OP_INV_BIT_LOAD_CARRY || op == lsb_pkg::OP_INV_CARRY_STORE_BIT)) begin
      illegal = 1'b1; // RQ14 RQ16 RQ18 RQ20 RQ22
    end
  end
endmodule : lsb_bit_unit

// [verilog/lsb_alu.sv]
`timescale 1ns/1ps
module lsb_alu (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request from the decoder
  input wire logic req_valid,
  input wire lsb_pkg::lsb_req_s req,
  output logic req_ready,
  // Answer to the register file and flags
  output logic rsp_valid,
  output lsb_pkg::lsb_rsp_s rsp,
  // Byte memory port
  output logic mem_rd_req,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_req,
  input wire logic mem_wr_ack,
  output logic [lsb_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wr_data
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_RD = 2'h2,
    ST_WR = 2'h3
  } lsb_state_e;

  lsb_state_e state_reg;
  lsb_state_e state_next;
  lsb_pkg::lsb_req_s req_reg;
  lsb_pkg::lsb_rsp_s rsp_reg;
  lsb_pkg::lsb_rsp_s rsp_next;
  lsb_pkg::lsb_rsp_s pend_reg;
  logic rsp_valid_reg;
  logic req_ready_reg;
  logic mem_rd_req_reg;
  logic mem_wr_req_reg;
  logic [lsb_pkg::ADDR_W-1:0] mem_addr_reg;
  logic [7:0] mem_wr_data_reg;
  logic [7:0] rd_byte_reg;

  logic take;
  logic bit_op;
  logic mem_bit;
  logic [31:0] opnd;
  logic [2:0] idx;
  logic [7:0] bit_byte_in;
  logic [31:0] w_result;
  logic w_c;
  logic w_c_upd;
  logic w_n;
  logic w_z;
  logic w_v;
  logic [7:0] b_byte;
  logic b_writes;
  logic b_c;
  logic b_c_upd;
  logic b_z;
  logic b_z_upd;
  logic b_illegal;
  logic mem_write_back;

  assign take = req_valid && req_ready_reg;
  assign bit_op = lsb_pkg::is_bit_op(req_reg.op);
  assign mem_bit = bit_op && req_reg.mem_operand;
  assign opnd = req_reg.use_imm ? req_reg.imm : req_reg.source_register;
  // Index from the immediate field or low three bits of a register
  assign idx = req_reg.idx_from_reg ? req_reg.source_register[2:0] : req_reg.bit_imm; // RQ9
  assign bit_byte_in = mem_bit ? rd_byte_reg : req_reg.dst[7:0];
  assign mem_write_back = mem_bit && b_writes && !b_illegal;

  lsb_word_unit u_word (
    .op(req_reg.op),
    .size(req_reg.size),
    .dst(req_reg.dst),
    .opnd(opnd),
    .carry_in(req_reg.carry),
    .result(w_result),
    .c_out(w_c),
    .c_upd(w_c_upd),
    .n_out(w_n),
    .z_out(w_z),
    .v_out(w_v)
  );

  lsb_bit_unit u_bit (
    .op(req_reg.op),
    .byte_in(bit_byte_in),
    .idx(idx),
    .idx_from_reg(req_reg.idx_from_reg),
    .carry_in(req_reg.carry),
    .byte_out(b_byte),
    .writes(b_writes),
    .c_out(b_c),
    .c_upd(b_c_upd),
    .z_out(b_z),
    .z_upd(b_z_upd),
    .illegal(b_illegal)
  );

  // Answer assembled during the execute cycle
  always_comb begin
    rsp_next = '0;
    if (bit_op) begin
      rsp_next.result = {req_reg.dst[31:8], b_byte};
      rsp_next.reg_we = b_writes && !req_reg.mem_operand && !b_illegal; // RQ21
      rsp_next.c = b_c;
      rsp_next.z = b_z;
      rsp_next.c_upd = b_c_upd && !b_illegal;
      rsp_next.z_upd = b_z_upd && !b_illegal;
      rsp_next.illegal = b_illegal;
    end else begin
      rsp_next.result = w_result; // RQ1 RQ2 RQ3 RQ4
      rsp_next.reg_we = 1'b1;
      rsp_next.c = w_c;
      rsp_next.z = w_z;
      rsp_next.n = w_n;
      rsp_next.v = w_v;
      rsp_next.c_upd = w_c_upd;
      rsp_next.z_upd = 1'b1;
      rsp_next.nv_upd = 1'b1;
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          if (lsb_pkg::is_bit_op(req.op) && req.mem_operand) state_next = ST_RD;
          else state_next = ST_EXEC;
        end
      end
      ST_RD: begin
        if (mem_rd_ack) state_next = ST_EXEC; // RQ23
      end
      ST_EXEC: begin
        if (mem_write_back) state_next = ST_WR;
        else state_next = ST_IDLE;
      end
      ST_WR: begin
        if (mem_wr_ack) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) req_reg <= '0;
    else if (take) req_reg <= req;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) req_ready_reg <= 1'b1;
    else if (take) req_ready_reg <= 1'b0;
    else if (state_next == ST_IDLE) req_ready_reg <= 1'b1;
  end

  // Memory read of the operand byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rd_req_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
    end else if (take && lsb_pkg::is_bit_op(req.op) && req.mem_operand) begin
      mem_rd_req_reg <= 1'b1;
    end else if (state_reg == ST_RD && mem_rd_ack) begin
      mem_rd_req_reg <= 1'b0;
      rd_byte_reg <= mem_rd_data; // RQ23
    end
  end

  // Write back to the same address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_wr_req_reg <= 1'b0;
      mem_wr_data_reg <= 8'h00;
    end else if (state_reg == ST_EXEC && mem_write_back) begin
      mem_wr_req_reg <= 1'b1;
      mem_wr_data_reg <= b_byte; // RQ23
    end else if (state_reg == ST_WR && mem_wr_ack) begin
      mem_wr_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) mem_addr_reg <= '0;
    else if (take) mem_addr_reg <= req.mem_addr; // RQ23
  end

  // Answer pulse; held back until a memory write completes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
      pend_reg <= '0;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (state_reg == ST_EXEC && !mem_write_back) begin
        rsp_valid_reg <= 1'b1;
        rsp_reg <= rsp_next;
      end else if (state_reg == ST_EXEC) begin
        pend_reg <= rsp_next;
      end else if (state_reg == ST_WR && mem_wr_ack) begin
        rsp_valid_reg <= 1'b1;
        rsp_reg <= pend_reg;
      end
    end
  end

  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp = rsp_reg;
  assign mem_rd_req = mem_rd_req_reg;
  assign mem_wr_req = mem_wr_req_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wr_data = mem_wr_data_reg;

  // Checks
  logic exec_reg_op;
  logic [7:0] chk_dst_lo;
  logic [7:0] chk_opnd_lo;
  logic [31:0] chk_dst;
  logic chk_carry;
  logic [2:0] chk_idx;
  assign exec_reg_op = (state_reg == ST_EXEC) && !req_reg.mem_operand;
  assign chk_dst_lo = req_reg.dst[7:0];
  assign chk_opnd_lo = opnd[7:0];
  assign chk_dst = req_reg.dst;
  assign chk_carry = req_reg.carry;
  assign chk_idx = idx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_and; // RQ1
    exec_reg_op && req_reg.op == lsb_pkg::OP_AND |=>
      rsp_valid && rsp.reg_we && rsp.result[7:0] == ($past(chk_dst_lo) & $past(chk_opnd_lo));
  endproperty
  a_and: assert property (p_and) else $error("AND result wrong"); // RQ1

  property p_or; // RQ2
    exec_reg_op && req_reg.op == lsb_pkg::OP_OR |=>
      rsp_valid && rsp.result[7:0] == ($past(chk_dst_lo) | $past(chk_opnd_lo));
  endproperty
  a_or: assert property (p_or) else $error("OR result wrong"); // RQ2

  property p_xor; // RQ3
    exec_reg_op && req_reg.op == lsb_pkg::OP_XOR |=>
      rsp_valid && rsp.result[7:0] == ($past(chk_dst_lo) ^ $past(chk_opnd_lo));
  endproperty
  a_xor: assert property (p_xor) else $error("XOR result wrong"); // RQ3

  property p_not_long; // RQ4
    exec_reg_op && req_reg.op == lsb_pkg::OP_NOT && req_reg.size == lsb_pkg::SZ_LONG |=>
      rsp_valid && rsp.result == ~$past(chk_dst);
  endproperty
  a_not_long: assert property (p_not_long) else $error("complement wrong"); // RQ4

  property p_arith_shift_right_sign; // RQ5
    exec_reg_op && req_reg.op == lsb_pkg::OP_ARITH_SHIFT_RIGHT
      && req_reg.size == lsb_pkg::SZ_BYTE |=>
      rsp.result[7:6] == {2{$past(chk_dst_lo[7])}} && rsp.c == $past(chk_dst_lo[0]);
  endproperty
  a_arith_shift_right_sign: assert property (p_arith_shift_right_sign) else $error("sign not kept"); // RQ5

  property p_logic_shift_right; // RQ6
    exec_reg_op && req_reg.op == lsb_pkg::OP_LOGIC_SHIFT_RIGHT
      && req_reg.size == lsb_pkg::SZ_LONG |=>
      rsp.result == {1'b0, $past(chk_dst[31:1])} && rsp.c_upd;
  endproperty
  a_logic_shift_right: assert property (p_logic_shift_right) else $error("logical shift wrong"); // RQ6

  property p_rotate_left_byte; // RQ7
    exec_reg_op && req_reg.op == lsb_pkg::OP_ROTATE_LEFT && req_reg.size == lsb_pkg::SZ_BYTE
      |=> rsp.result[7:0] == {$past(chk_dst_lo[6:0]), $past(chk_dst_lo[7])};
  endproperty
  a_rotate_left_byte: assert property (p_rotate_left_byte) else $error("rotate wrong"); // RQ7

  property p_rotate_right_via_carry_long; // RQ8
    exec_reg_op && req_reg.op == lsb_pkg::OP_ROTATE_RIGHT_VIA_CARRY
      && req_reg.size == lsb_pkg::SZ_LONG |=>
      rsp.result == {$past(chk_carry), $past(chk_dst[31:1])} && rsp.c == $past(chk_dst[0]);
  endproperty
  a_rotate_right_via_carry_long: assert property (p_rotate_right_via_carry_long)
    else $error("rotate via carry wrong"); // RQ8

  property p_bit_force_one; // RQ9
    exec_reg_op && req_reg.op == lsb_pkg::OP_BIT_FORCE_ONE |=>
      rsp.reg_we && rsp.result[$past(chk_idx)] == 1'b1;
  endproperty
  a_bit_force_one: assert property (p_bit_force_one) else $error("bit not set"); // RQ9

  property p_probe; // RQ12
    exec_reg_op && req_reg.op == lsb_pkg::OP_BIT_PROBE |=>
      !rsp.reg_we && rsp.z_upd && rsp.z == !$past(chk_dst_lo[chk_idx]);
  endproperty
  a_probe: assert property (p_probe) else $error("probe flag wrong"); // RQ12

  property p_inv_imm_only; // RQ14
    state_reg == ST_EXEC && req_reg.op == lsb_pkg::OP_INV_BIT_AND_TO_CARRY
      && req_reg.idx_from_reg |=> rsp_valid && rsp.illegal && !mem_wr_req && !rsp.c_upd;
  endproperty
  a_inv_imm_only: assert property (p_inv_imm_only) else $error("register index taken"); // RQ14

  property p_store_carry; // RQ21
    exec_reg_op && req_reg.op == lsb_pkg::OP_CARRY_STORE_BIT |=>
      rsp.result[$past(chk_idx)] == $past(chk_carry) && rsp.result[31:8] == $past(chk_dst[31:8]);
  endproperty
  a_store_carry: assert property (p_store_carry) else $error("carry store wrong"); // RQ21

  property p_mem_rmw; // RQ23
    $rose(mem_wr_req) |->
      $countones(mem_wr_data ^ rd_byte_reg) <= 1 && $stable(mem_addr) && !mem_rd_req;
  endproperty
  a_mem_rmw: assert property (p_mem_rmw) else $error("write back not one bit"); // RQ23
endmodule : lsb_alu

// [test/lsb_mem_model.sv]
`timescale 1ns/1ps
module lsb_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Answer delay in cycles
  input wire logic [1:0] lag,
  // Byte memory port
  input wire logic mem_rd_req,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_data,
  input wire logic mem_wr_req,
  output logic mem_wr_ack,
  input wire logic [lsb_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wr_data
);
  logic [7:0] mem [0:(1<<lsb_pkg::ADDR_W)-1];
  logic [7:0] last_byte;
  logic [2:0] wait_cnt;
  int wr_count;
  initial begin
    for (int a = 0; a < (1 << lsb_pkg::ADDR_W); a++) begin
      mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5A;
    end
  end
  // Ack once the request has waited lag cycles
  assign mem_rd_ack = mem_rd_req && (wait_cnt >= {1'b0, lag});
  assign mem_wr_ack = mem_wr_req && (wait_cnt >= {1'b0, lag});
  // Read data only valid with the ack, else the inverse of the last byte
  assign mem_rd_data = mem_rd_ack ? mem[mem_addr] : ~last_byte;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 3'h0;
      last_byte <= 8'h00;
      wr_count <= 0;
    end else begin
      if (mem_rd_ack || mem_wr_ack || !(mem_rd_req || mem_wr_req)) begin
        wait_cnt <= 3'h0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
      if (mem_rd_ack) begin
        last_byte <= mem[mem_addr];
      end
      if (mem_wr_ack) begin
        mem[mem_addr] <= mem_wr_data;
        wr_count <= wr_count + 1;
      end
    end
  end
endmodule : lsb_mem_model

// [test/logic_shift_bit_alu_tb.sv]
`timescale 1ns/1ps
module logic_shift_bit_alu_tb;
  logic clk, rst_b, req_valid, req_ready, rsp_valid;
  lsb_pkg::lsb_req_s req;
  lsb_pkg::lsb_rsp_s rsp;
  logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic [lsb_pkg::ADDR_W-1:0] mem_addr;
  logic [1:0] lag;
  int mismatches, checks_done;
  logic [7:0] em [int];

  lsb_alu i_lsb_alu (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .mem_rd_req(mem_rd_req),
    .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req),
    .mem_wr_ack(mem_wr_ack), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data));
  lsb_mem_model i_lsb_mem_model (.clk(clk), .rst_b(rst_b), .lag(lag),
    .mem_rd_req(mem_rd_req), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
    .mem_wr_req(mem_wr_req), .mem_wr_ack(mem_wr_ack), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_word(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string n, input logic x, input logic g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", n, x, g);
    end
  endtask : cmp_flag

  task automatic timed_out(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("CHECK FAILED handshake expected 1 seen 0");
      wrap_up();
    end
  endtask : timed_out

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return em.exists(a) ? em[a] : a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mem_byte

  // Reference behaviour of one operation
  task automatic model(input lsb_pkg::lsb_req_s r, output lsb_pkg::lsb_rsp_s e,
                       output logic mw, output logic [7:0] b);
    logic [31:0] m, d, o, x;
    logic [4:0] p;
    logic [2:0] i;
    logic bt;
    m = r.size == lsb_pkg::SZ_BYTE ? 32'h0000_00FF :
        r.size == lsb_pkg::SZ_WORD ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    p = r.size == lsb_pkg::SZ_BYTE ? 5'h07 : r.size == lsb_pkg::SZ_WORD ? 5'h0F : 5'h1F;
    d = r.dst & m;
    o = r.use_imm ? r.imm : r.source_register;
    b = r.mem_operand ? mem_byte(r.mem_addr) : r.dst[7:0];
    i = r.idx_from_reg ? r.source_register[2:0] : r.bit_imm;
    bt = b[i];
    e = '0;
    x = 32'h0;
    e.illegal = r.op >= 5'h10 && r.op[0] && r.idx_from_reg;
    e.c_upd = (r.op inside {[5'h04:5'h0B], [5'h10:5'h17]}) && !e.illegal;
    case (r.op)
      5'h00: x = d & o;
      5'h01: x = d | o;
      5'h02: x = d ^ o;
      5'h03: x = ~d;
      5'h04, 5'h06: x = d << 1;
      5'h05: x = (d >> 1) | (d & (32'h1 << p));
      5'h07: x = d >> 1;
      5'h08: x = (d << 1) | {31'h0, d[p]};
      5'h09: x = (d >> 1) | ({31'h0, d[0]} << p);
      5'h0A: x = (d << 1) | {31'h0, r.carry};
      5'h0B: x = (d >> 1) | ({31'h0, r.carry} << p);
      5'h0C: b[i] = 1'b1;
      5'h0D: b[i] = 1'b0;
      5'h0E: b[i] = ~bt;
      5'h0F: e.z = ~bt;
      5'h10: e.c = r.carry & bt;
      5'h11: e.c = r.carry & ~bt;
      5'h12: e.c = r.carry | bt;
      5'h13: e.c = r.carry | ~bt;
      5'h14: e.c = r.carry ^ bt;
      5'h15: e.c = r.carry ^ ~bt;
      5'h16: e.c = bt;
      5'h17: e.c = ~bt;
      5'h18: b[i] = r.carry;
      5'h19: b[i] = ~r.carry;
      default: x = 32'h0;
    endcase
    if (r.op < 5'h0C) begin
      e.c = r.op[0] ? d[0] : d[p];
      e.reg_we = 1'b1;
      e.result = (r.dst & ~m) | (x & m);
      e.z_upd = 1'b1;
      e.nv_upd = 1'b1;
      e.z = (x & m) == 32'h0;
      e.n = x[p];
      e.v = (r.op == 5'h04) && (d[p] ^ d[p - 5'h01]);
      mw = 1'b0;
    end else begin
      e.z_upd = r.op == 5'h0F;
      mw = (r.op inside {[5'h0C:5'h0E], 5'h18, 5'h19}) && !e.illegal;
      e.reg_we = mw && !r.mem_operand;
      e.result = {r.dst[31:8], b};
      mw = mw && r.mem_operand;
    end
  endtask : model

  task automatic run_op(input lsb_pkg::lsb_req_s r);
    lsb_pkg::lsb_rsp_s e;
    logic mw;
    logic [7:0] mb;
    int n;
    int wc;
    model(r, e, mw, mb);
    wc = i_lsb_mem_model.wr_count;
    lag = 2'($urandom_range(3, 0));
    req = r;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    timed_out(n);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    timed_out(n);
    cmp_flag("illegal", e.illegal, rsp.illegal);
    cmp_flag("reg_we", e.reg_we, rsp.reg_we);
    if (e.reg_we && r.op < 5'h0C) cmp_word("result", e.result, rsp.result);
    if (e.reg_we && r.op >= 5'h0C) cmp_word("bit_result", e.result, rsp.result);
    cmp_flag("c_upd", e.c_upd, rsp.c_upd);
    if (e.c_upd) cmp_flag("carry", e.c, rsp.c);
    cmp_flag("z_upd", e.z_upd, rsp.z_upd);
    if (e.z_upd) cmp_flag("zero", e.z, rsp.z);
    cmp_flag("nv_upd", e.nv_upd, rsp.nv_upd);
    if (e.nv_upd) cmp_flag("negative", e.n, rsp.n);
    if (e.nv_upd) cmp_flag("overflow", e.v, rsp.v);
    cmp_word("mem_writes", 32'(wc) + {31'h0, mw}, i_lsb_mem_model.wr_count);
    if (mw) cmp_word("mem_byte", {24'h0, mb}, {24'h0, i_lsb_mem_model.mem[r.mem_addr]});
    if (mw) em[r.mem_addr] = mb;
  endtask : run_op

  initial begin
    lsb_pkg::lsb_req_s r;
    logic [127:0] t;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    lag = 2'h0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(32'hD741));
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // Every operation, several rounds, random operands and indices
    for (int k = 0; k < 8; k++) begin
      for (int o = 0; o < 26; o++) begin
        t = {$urandom, $urandom, $urandom, $urandom};
        r = t[$bits(lsb_pkg::lsb_req_s)-1:0];
        r.op = lsb_pkg::lsb_op_e'(o);
        r.size = lsb_pkg::lsb_size_e'($urandom_range(2, 0));
        run_op(r);
      end
    end
    wrap_up();
  end
endmodule : logic_shift_bit_alu_tb
